/* jhc_pkg.sv */
/*
 Package for the jog and homing command logic: number formats, defaults,
 states and the packed carriers shared by the design.
 Assumes fixed-point velocities in 0.001 unit/s and distances in 0.000001 unit.
*/
package jhc_pkg;

	localparam int JHC_VEL_W = 48;
	localparam int JHC_POS_W = 64;
	// Velocity in 1e-3 unit/s, distance and position in 1e-6 unit
	localparam logic signed [JHC_VEL_W-1:0] JHC_VEL_LIMIT = 48'sh0000_0009_502f_9000; // 4e+07 * 1000
	localparam logic signed [JHC_VEL_W-1:0] JHC_VEL1_LIN = -48'sh0000_0000_0000_1388; // -5.000
	localparam logic signed [JHC_VEL_W-1:0] JHC_VEL1_ROT = -48'sh0000_0000_0002_bf20; // -180.000
	localparam logic signed [JHC_VEL_W-1:0] JHC_VEL2_LIN = 48'sh0000_0000_0000_1388; // 5.000
	localparam logic signed [JHC_VEL_W-1:0] JHC_VEL2_ROT = 48'sh0000_0000_0002_bf20; // 180.000
	localparam logic [JHC_POS_W-1:0] JHC_DIST_LIN = 64'h0000_0000_000f_4240; // 1.000000
	localparam logic [JHC_POS_W-1:0] JHC_DIST_ROT = 64'h0000_0000_0225_5100; // 36.000000
	localparam logic [JHC_POS_W-1:0] JHC_DIST_ZERO = 64'h0000_0000_0000_0000;
	localparam int JHC_HOME_SET_BIT = 11;
	localparam logic [15:0] JHC_STATUS_RST = 16'h0000;

	typedef enum {
		JHC_IDLE,
		JHC_JOG_CONT,
		JHC_JOG_INCR,
		JHC_HOMING
	} jhc_state_t;

	typedef struct packed {
		logic jog_one_request;
		logic jog_two_request;
		logic incremental_select;
		logic homing_trigger;
		logic homing_type_select;
	} jhc_cmd_t;

	typedef struct packed {
		logic signed [JHC_VEL_W-1:0] velocity;
		logic [JHC_POS_W-1:0] distance;
		logic incremental;
		logic run;
		logic abort;
	} jhc_move_t;

endpackage

/* jhc_jog_homing.sv */
/*
 Jog and homing command logic for one positioning axis.
 Assumes a motion profile generator that executes move_cmd using the
 acceleration limits passed through, and reports motion_busy, homing_done.
*/
// Overview of operation
// - Jog one velocity signed, limited, defaulted
// - Jog two velocity signed, limited, defaulted
// - Jog one distance non-negative, defaulted
// - Jog two distance separate, same defaults
// - Incremental jog one starts on rising edge
// - Jog one request low aborts incremental move
// - Incremental jog two starts on rising edge
// - Jog two request low aborts incremental move
// - Jog ramps use max acceleration/deceleration
// - Continuous jog one while request held
// - Incremental jog one moves distance, stops
// - Continuous jog two while request held
// - Incremental jog two moves distance, stops
// - Homing trigger rising edge starts selected homing
// - Homing trigger falling edge interrupts homing
// - Active homing start only when motion finished
// - Active homing start clears home set flag
// - Passive homing start keeps home set flag
// - Unconnected command inputs read as low
// - Homing completion loads home position value
`timescale 1ns/1ps
module jhc_jog_homing
	import jhc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic rotary_axis,
	input wire jhc_cmd_t cmd,
	input wire logic cmd_connected,
	input wire logic vel_write,
	input wire logic signed [JHC_VEL_W-1:0] jog_one_velocity_in,
	input wire logic signed [JHC_VEL_W-1:0] jog_two_velocity_in,
	input wire logic dist_write,
	input wire logic signed [JHC_POS_W-1:0] jog_one_distance_in,
	input wire logic signed [JHC_POS_W-1:0] jog_two_distance_in,
	input wire logic [JHC_VEL_W-1:0] max_acceleration,
	input wire logic [JHC_VEL_W-1:0] max_deceleration,
	input wire logic signed [JHC_POS_W-1:0] home_position_value,
	input wire logic motion_busy,
	input wire logic move_done,
	input wire logic homing_done,
	output jhc_move_t move_cmd,
	output logic [JHC_VEL_W-1:0] ramp_accel,
	output logic [JHC_VEL_W-1:0] ramp_decel,
	output logic homing_start,
	output logic homing_active_type,
	output logic homing_interrupt,
	output logic homing_busy,
	output logic position_load,
	output logic signed [JHC_POS_W-1:0] position_load_value,
	output logic [15:0] status,
	output logic signed [JHC_VEL_W-1:0] jog_one_velocity,
	output logic signed [JHC_VEL_W-1:0] jog_two_velocity,
	output logic [JHC_POS_W-1:0] jog_one_distance,
	output logic [JHC_POS_W-1:0] jog_two_distance
);

	jhc_cmd_t in_cmd;
	jhc_cmd_t prev_cmd;
	jhc_state_t state;
	logic owner_two;
	logic jog_one_rise;
	logic jog_two_rise;
	logic home_rise;
	logic home_fall;
	logic req_owner;
	logic any_req;
	logic jog_lock;

	// Floating command sinks read as zero
	assign in_cmd = cmd_connected ? cmd : '0;

	assign jog_one_rise = in_cmd.jog_one_request & ~prev_cmd.jog_one_request;
	assign jog_two_rise = in_cmd.jog_two_request & ~prev_cmd.jog_two_request;
	assign home_rise = in_cmd.homing_trigger & ~prev_cmd.homing_trigger;
	assign home_fall = ~in_cmd.homing_trigger & prev_cmd.homing_trigger;
	assign any_req = in_cmd.jog_one_request | in_cmd.jog_two_request;
	assign req_owner = owner_two ? in_cmd.jog_two_request : in_cmd.jog_one_request;

	function automatic logic signed [JHC_VEL_W-1:0] jhc_clamp_vel(input logic signed [JHC_VEL_W-1:0] v);
		if (v > JHC_VEL_LIMIT) begin
			return JHC_VEL_LIMIT;
		end else if (v < -JHC_VEL_LIMIT) begin
			return -JHC_VEL_LIMIT;
		end
		return v;
	endfunction

	function automatic logic [JHC_POS_W-1:0] jhc_clamp_dist(input logic signed [JHC_POS_W-1:0] d);
		if (d < 0) begin
			return JHC_DIST_ZERO;
		end
		return d;
	endfunction

	always_ff @(posedge clk) begin
		if (srst) begin
			prev_cmd <= '0;
		end else begin
			prev_cmd <= in_cmd;
		end
	end

	// Velocity setpoints with unit-dependent defaults, switched only while owner_two is low
	always_ff @(posedge clk) begin
		if (srst) begin
			jog_one_velocity <= JHC_VEL1_LIN;
			jog_two_velocity <= JHC_VEL2_LIN;
		end else if (vel_write) begin
			jog_one_velocity <= jhc_clamp_vel(jog_one_velocity_in);
			jog_two_velocity <= jhc_clamp_vel(jog_two_velocity_in);
		end else if (prev_cmd == '0 && state == JHC_IDLE && !jog_lock && !owner_two && !motion_busy
			&& jog_one_velocity == (rotary_axis ? JHC_VEL1_LIN : JHC_VEL1_ROT)) begin
			jog_one_velocity <= rotary_axis ? JHC_VEL1_ROT : JHC_VEL1_LIN;
			jog_two_velocity <= rotary_axis ? JHC_VEL2_ROT : JHC_VEL2_LIN;
		end
	end

	// Traversing distances, never negative
	always_ff @(posedge clk) begin
		if (srst) begin
			jog_one_distance <= JHC_DIST_LIN;
			jog_two_distance <= JHC_DIST_LIN;
		end else if (dist_write) begin
			jog_one_distance <= jhc_clamp_dist(jog_one_distance_in);
			jog_two_distance <= jhc_clamp_dist(jog_two_distance_in);
		end else if (state == JHC_IDLE && !motion_busy
			&& jog_one_distance == (rotary_axis ? JHC_DIST_LIN : JHC_DIST_ROT)
			&& jog_two_distance == jog_one_distance) begin
			jog_one_distance <= rotary_axis ? JHC_DIST_ROT : JHC_DIST_LIN;
			jog_two_distance <= rotary_axis ? JHC_DIST_ROT : JHC_DIST_LIN;
		end
	end

	// Ramp limits follow the configured maxima
	always_ff @(posedge clk) begin
		if (srst) begin
			ramp_accel <= '0;
			ramp_decel <= '0;
		end else begin
			ramp_accel <= max_acceleration;
			ramp_decel <= max_deceleration;
		end
	end

	// Jog arbitration and state machine
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= JHC_IDLE;
			owner_two <= 1'b0;
			jog_lock <= 1'b0;
			move_cmd <= '0;
		end else begin
			move_cmd.abort <= 1'b0;
			if (!any_req) begin
				jog_lock <= 1'b0;
			end
			case (state)
				JHC_IDLE: begin
					move_cmd.run <= 1'b0;
					if (!jog_lock && (jog_one_rise || jog_two_rise)) begin
						// Simultaneous edges give channel one priority
						owner_two <= !jog_one_rise;
						jog_lock <= 1'b1;
						move_cmd.run <= 1'b1;
						move_cmd.incremental <= in_cmd.incremental_select;
						move_cmd.velocity <= jog_one_rise ? jog_one_velocity : jog_two_velocity;
						move_cmd.distance <= jog_one_rise ? jog_one_distance : jog_two_distance;
						if (in_cmd.incremental_select) begin
							state <= JHC_JOG_INCR;
						end else begin
							state <= JHC_JOG_CONT;
						end
					end else if (home_rise && !(in_cmd.homing_type_select == 1'b0 && motion_busy)) begin
						state <= JHC_HOMING;
					end
				end
				JHC_JOG_CONT: begin
					if (!req_owner) begin
						move_cmd.run <= 1'b0;
						state <= JHC_IDLE;
					end
				end
				JHC_JOG_INCR: begin
					if (!req_owner) begin
						move_cmd.run <= 1'b0;
						move_cmd.abort <= 1'b1;
						state <= JHC_IDLE;
					end else if (move_done) begin
						move_cmd.run <= 1'b0;
						state <= JHC_IDLE;
					end
				end
				JHC_HOMING: begin
					if (home_fall || homing_done) begin
						state <= JHC_IDLE;
					end
				end
				default: begin
					state <= JHC_IDLE;
				end
			endcase
		end
	end

	// Homing start and interrupt pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			homing_start <= 1'b0;
			homing_active_type <= 1'b0;
			homing_interrupt <= 1'b0;
			homing_busy <= 1'b0;
		end else begin
			homing_start <= 1'b0;
			homing_interrupt <= 1'b0;
			if (state == JHC_IDLE && !jog_lock && !jog_one_rise && !jog_two_rise && home_rise
				&& !(in_cmd.homing_type_select == 1'b0 && motion_busy)) begin
				homing_start <= 1'b1;
				homing_active_type <= ~in_cmd.homing_type_select;
				homing_busy <= 1'b1;
			end else if (state == JHC_HOMING && home_fall) begin
				homing_interrupt <= 1'b1;
				homing_busy <= 1'b0;
			end else if (state == JHC_HOMING && homing_done) begin
				homing_busy <= 1'b0;
			end
		end
	end

	// Home-set status flag and actual position load
	always_ff @(posedge clk) begin
		if (srst) begin
			status <= JHC_STATUS_RST;
			position_load <= 1'b0;
			position_load_value <= '0;
		end else begin
			position_load <= 1'b0;
			if (state == JHC_HOMING && homing_done && !home_fall) begin
				status[JHC_HOME_SET_BIT] <= 1'b1;
				position_load <= 1'b1;
				position_load_value <= home_position_value;
			end else if (state == JHC_IDLE && !jog_lock && !jog_one_rise && !jog_two_rise && home_rise
				&& !in_cmd.homing_type_select && !motion_busy) begin
				status[JHC_HOME_SET_BIT] <= 1'b0;
			end
			// Passive homing start leaves the flag alone
		end
	end

endmodule

/* jhc_jog_homing_assertions.sv */
/* Checker for the jog and homing command logic.
 Assumes binding to the top module ports. */
`timescale 1ns/1ps
module jhc_chk
	import jhc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire jhc_cmd_t cmd,
	input wire logic cmd_connected,
	input wire logic motion_busy,
	input wire logic homing_done,
	input wire jhc_move_t move_cmd,
	input wire logic signed [JHC_VEL_W-1:0] jog_one_velocity,
	input wire logic homing_start,
	input wire logic homing_interrupt,
	input wire logic homing_busy,
	input wire logic position_load,
	input wire logic [15:0] status
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire idle = !move_cmd.run && !homing_busy && cmd_connected;
	wire anyj = cmd.jog_one_request || cmd.jog_two_request;
	property p_jog1; idle && $rose(cmd.jog_one_request) && !$past(cmd.jog_two_request)
		|=> move_cmd.run && move_cmd.velocity == jog_one_velocity; endproperty
	a_jog1: assert property (p_jog1) else $error("jog one not started");
	property p_abort; move_cmd.run && move_cmd.incremental && !anyj |=> !move_cmd.run && move_cmd.abort; endproperty
	a_abort: assert property (p_abort) else $error("incremental not aborted");
	property p_hstart; idle && !anyj && !$past(anyj) && $rose(cmd.homing_trigger) && !(motion_busy && !cmd.homing_type_select)
		|=> homing_start && homing_busy; endproperty
	a_hstart: assert property (p_hstart) else $error("homing not started");
	property p_refuse; $rose(cmd.homing_trigger) && !cmd.homing_type_select && motion_busy |=> !homing_start; endproperty
	a_refuse: assert property (p_refuse) else $error("active homing while moving");
	property p_clear; homing_start && !$past(cmd.homing_type_select) |-> !status[JHC_HOME_SET_BIT]; endproperty
	a_clear: assert property (p_clear) else $error("home flag not cleared");
	property p_keep; homing_start && $past(cmd.homing_type_select) |-> $stable(status); endproperty
	a_keep: assert property (p_keep) else $error("home flag changed");
	property p_intr; homing_busy && cmd_connected && $fell(cmd.homing_trigger) |=> homing_interrupt && !homing_busy; endproperty
	a_intr: assert property (p_intr) else $error("homing not interrupted");
	property p_done; homing_busy && homing_done && cmd.homing_trigger && cmd_connected
		|=> ##[0:1] position_load && status[JHC_HOME_SET_BIT]; endproperty
	a_done: assert property (p_done) else $error("home position not loaded");
endmodule
bind jhc_jog_homing jhc_chk i_jhc_chk (.*);

/* jhc_profile_model.sv */
/* Profile generator model: busy while a move runs, finishes incremental moves and homing.
 Assumes registered move_cmd and homing_busy from the block. */
`timescale 1ns/1ps
module jhc_profile_model
	import jhc_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire jhc_move_t move_cmd,
	input wire logic homing_busy,
	input wire logic slow,
	output logic motion_busy,
	output logic move_done,
	output logic homing_done
);
	logic [3:0] cnt;
	always_ff @(posedge clk) begin
		cnt <= (srst || !(move_cmd.run || homing_busy)) ? 4'h0 : cnt + 4'h1;
	end
	assign motion_busy = move_cmd.run;
	assign move_done = move_cmd.run && move_cmd.incremental && cnt == (slow ? 4'hc : 4'h4);
	assign homing_done = homing_busy && cnt == 4'h8;
endmodule

/* jhc_jog_homing_tb.sv */
/* Testbench for the jog and homing command logic.
 Assumes the profile model closes the motion loop. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t line %0d", $time, `__LINE__); end end
`define WAITF(x) begin for (int k = 0; k < 60 && !(x); k++) @(negedge clk); if (!(x)) begin errors++; conclude(); end end
module jhc_jog_homing_tb
	import jhc_pkg::*;
;
	logic clk = 0, srst = 1, rotary_axis = 0, cmd_connected = 0, vel_write = 0, dist_write = 0, slow = 0;
	jhc_cmd_t cmd = '0;
	logic signed [JHC_VEL_W-1:0] jog_one_velocity_in = '0, jog_two_velocity_in = '0;
	logic signed [JHC_POS_W-1:0] jog_one_distance_in = '0, jog_two_distance_in = '0;
	logic signed [JHC_POS_W-1:0] home_position_value = 64'sh0000_0000_0001_e240;
	logic [JHC_VEL_W-1:0] max_acceleration = 48'h0000_0000_1000, max_deceleration = 48'h0000_0000_2000;
	logic motion_busy, move_done, homing_done, homing_start, homing_active_type, homing_interrupt, homing_busy;
	logic position_load;
	jhc_move_t move_cmd;
	logic [JHC_VEL_W-1:0] ramp_accel, ramp_decel;
	logic signed [JHC_POS_W-1:0] position_load_value;
	logic [15:0] status;
	logic signed [JHC_VEL_W-1:0] jog_one_velocity, jog_two_velocity;
	logic [JHC_POS_W-1:0] jog_one_distance, jog_two_distance;
	int errors = 0, samples_checked = 0;
	always #20 clk = ~clk;
	jhc_jog_homing i_jhc_jog_homing (.*);
	jhc_profile_model i_jhc_profile_model (.*);
	task conclude;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Command bits: jog one, jog two, incremental, trigger, type
	task go(input jhc_cmd_t x, input int n);
		@(posedge clk);
		cmd <= x;
		repeat (n) @(negedge clk);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		srst <= 1'b0;
		cmd_connected <= 1'b1;
		@(negedge clk);
		@(negedge clk);
		`CHK(jog_one_velocity, JHC_VEL1_LIN)
		`CHK(jog_two_velocity, JHC_VEL2_LIN)
		`CHK(jog_one_distance, JHC_DIST_LIN)
		`CHK(jog_two_distance, JHC_DIST_LIN)
		`CHK(ramp_accel, max_acceleration)
		`CHK(ramp_decel, max_deceleration)
		@(posedge clk);
		jog_one_velocity_in <= 48'sh7fff_ffff_ffff;
		jog_two_velocity_in <= 48'sh0000_0000_0bb8;
		jog_one_distance_in <= -64'sh0000_0000_0000_0001;
		jog_two_distance_in <= 64'sh0000_0000_0000_07d0;
		vel_write <= 1'b1;
		dist_write <= 1'b1;
		@(posedge clk);
		vel_write <= 1'b0;
		dist_write <= 1'b0;
		@(negedge clk);
		`CHK(jog_one_velocity, JHC_VEL_LIMIT)
		`CHK(jog_two_velocity, 48'sh0000_0000_0bb8)
		`CHK(jog_one_distance, JHC_DIST_ZERO)
		`CHK(jog_two_distance, 64'h0000_0000_0000_07d0)
		go(5'b10000, 2);
		`CHK(move_cmd.run, 1'b1)
		`CHK(move_cmd.velocity, JHC_VEL_LIMIT)
		go(5'b11000, 3);
		`CHK(move_cmd.velocity, JHC_VEL_LIMIT)
		go(5'b01000, 2);
		`CHK(move_cmd.run, 1'b0)
		slow <= 1'b1;
		go(5'b00000, 2);
		go(5'b01100, 2);
		`CHK(move_cmd.incremental, 1'b1)
		`CHK(move_cmd.distance, 64'h0000_0000_0000_07d0)
		`CHK(move_cmd.velocity, 48'sh0000_0000_0bb8)
		`WAITF(!move_cmd.run)
		`CHK(move_cmd.abort, 1'b0)
		slow <= 1'b0;
		go(5'b00000, 2);
		go(5'b10100, 2);
		`CHK(move_cmd.distance, JHC_DIST_ZERO)
		go(5'b00100, 2);
		`CHK(move_cmd.abort, 1'b1)
		go(5'b10000, 2);
		go(5'b10010, 2);
		`CHK(homing_start, 1'b0)
		go(5'b00000, 2);
		go(5'b00010, 2);
		`CHK(homing_start, 1'b1)
		`CHK(homing_active_type, 1'b1)
		`CHK(status[JHC_HOME_SET_BIT], 1'b0)
		`WAITF(position_load)
		`CHK(position_load_value, home_position_value)
		`CHK(status[JHC_HOME_SET_BIT], 1'b1)
		go(5'b00000, 2);
		go(5'b00011, 2);
		`CHK(status[JHC_HOME_SET_BIT], 1'b1)
		`CHK(homing_active_type, 1'b0)
		go(5'b00001, 2);
		`CHK(homing_interrupt, 1'b1)
		@(posedge clk);
		cmd_connected <= 1'b0;
		go(5'b10000, 3);
		`CHK(move_cmd.run, 1'b0)
		conclude();
	end
endmodule
